// >>> aclsc_slot_ctrl.sv
// Slot enable control: APB register bank with crossing into the link clock
//
// Function
// [RULE1] Enable bit 4 sets audio receive
// [RULE2] Enable bit 3 sets LFE transmit
// [RULE3] Enable bit 2 sets center transmit
// [RULE4] Enable bit 1 sets surround transmit
// [RULE5] Enable bit 0 sets PCM transmit
// [RULE6] Disable bits 9, 8 clear GP slots
// [RULE7] Disable bits 7, 6 clear modem slots
// [RULE8] Disable bit 4 clears audio receive
// [RULE9] Disable bits 3..0 clear audio transmit
// [RULE10] Disable bits 31:10 and 5 do nothing
// [RULE11] Writes reach link after link clocks, pending
// [RULE12] Software checks pending before each write
// [RULE13] Long pending means link clock stopped
// [RULE14] Enable bit 16 reads write pending
// [RULE15] Enable bits 9..6 set GP, modem slots
// [RULE16] One state bit per slot, reset cleared
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module aclsc_slot_ctrl
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clk,
  output logic pcm_tx_slot_en,
  output logic surround_tx_slot_en,
  output logic center_tx_slot_en,
  output logic lfe_tx_slot_en,
  output logic audio_rx_slot_en,
  output logic modem_tx_slot_en,
  output logic modem_rx_slot_en,
  output logic gp_output_slot_en,
  output logic gp_input_slot_en
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  aclsc_pkg::aclsc_wr_e wr_state;
  logic [9:0] slot_state;
  logic [9:0] set_mask;
  logic [9:0] clr_mask;
  logic [9:0] link_state;
  logic req_tgl;
  logic ack_tgl;
  logic req_sync;
  logic ack_sync;
  logic link_rstn;
  logic setup_phase;
  logic access_done;
  logic hit_enable;
  logic hit_disable;
  logic write_pending;
  logic wr_go;
  logic ack_done;
  logic link_apply;
  logic [31:0] read_value;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Phase and address qualifiers
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign hit_enable = (paddr == aclsc_pkg::SLOT_ENABLE_OFF);
  assign hit_disable = (paddr == aclsc_pkg::SLOT_DISABLE_OFF);
  assign write_pending = (wr_state == aclsc_pkg::ACLSC_WR_BUSY);

  // Writes while busy are dropped so the crossing masks stay stable
  assign wr_go = access_done & pwrite & (hit_enable | hit_disable) & ~write_pending;

  // Read view of the registers
  always_comb
  begin
    read_value = aclsc_pkg::READ_ZERO;
    if (hit_enable)
    begin
      // [RULE14] pending flag view
      read_value[aclsc_pkg::PENDING_BIT] = write_pending;
      // [RULE16] current slot state
      read_value[aclsc_pkg::SLOT_W-1:0] = slot_state;
    end
    else if (hit_disable)
    begin
      read_value = aclsc_pkg::READ_ZERO; // Write-only register
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // One registered ready per transfer, raised from the setup cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      pready <= 1'b0;
    else
      pready <= setup_phase;
  end

  // Read data latched in the setup cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      prdata <= aclsc_pkg::READ_ZERO;
    else if (setup_phase && !pwrite)
      prdata <= read_value;
    else if (setup_phase)
      prdata <= aclsc_pkg::READ_ZERO;
  end

  // Unmapped addresses answer with an error
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      pslverr <= 1'b0;
    else if (setup_phase)
      pslverr <= ~(hit_enable | hit_disable);
    else
      pslverr <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Write capture
  // ----------------------------------------------------------------
  // Masks stay put while pending, so the link side may read them after the toggle
  // [RULE1] set mask from enable write
  // [RULE3] center set bit
  // [RULE4] surround set bit
  // [RULE5] PCM set bit
  // [RULE10] reserved bits stripped
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      set_mask <= aclsc_pkg::SLOT_RESET;
      clr_mask <= aclsc_pkg::SLOT_RESET;
    end
    else if (wr_go)
    begin
      set_mask <= hit_enable ? (pwdata[aclsc_pkg::SLOT_W-1:0] & aclsc_pkg::SLOT_MASK)
        : aclsc_pkg::SLOT_RESET;
      clr_mask <= hit_disable ? (pwdata[aclsc_pkg::SLOT_W-1:0] & aclsc_pkg::SLOT_MASK)
        : aclsc_pkg::SLOT_RESET;
    end
  end

  // Request toggle toward the link side
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      req_tgl <= 1'b0;
    else if (wr_go)
      req_tgl <= ~req_tgl;
  end

  // ----------------------------------------------------------------
  // Pending handshake
  // ----------------------------------------------------------------
  assign ack_done = write_pending & (ack_sync == req_tgl);

  // [RULE11] busy until link acknowledges
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      wr_state <= aclsc_pkg::ACLSC_WR_IDLE;
    else
    begin
      case (wr_state)
        aclsc_pkg::ACLSC_WR_IDLE:
        begin
          if (wr_go)
            wr_state <= aclsc_pkg::ACLSC_WR_BUSY;
        end
        aclsc_pkg::ACLSC_WR_BUSY:
        begin
          if (ack_done)
            wr_state <= aclsc_pkg::ACLSC_WR_IDLE;
        end
        default:
        begin
          wr_state <= aclsc_pkg::ACLSC_WR_IDLE;
        end
      endcase
    end
  end

  // [RULE16] host copy of slot state
  // [RULE9] clear mask wins
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      slot_state <= aclsc_pkg::SLOT_RESET;
    else if (ack_done)
      slot_state <= (slot_state | set_mask) & ~clr_mask;
  end

  // Acknowledge toggle back from the link side
  aclsc_sync3 #(.RESET_VALUE(1'b0)) u_ack_sync
  (
    .clk(ref_clk),
    .rstn(rstn),
    .din(ack_tgl),
    .dout(ack_sync)
  );

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // Reset carried into the link clock
  aclsc_sync3 #(.RESET_VALUE(1'b0)) u_rst_sync
  (
    .clk(bit_clk),
    .rstn(1'b1),
    .din(rstn),
    .dout(link_rstn)
  );

  // Request toggle into the link clock
  aclsc_sync3 #(.RESET_VALUE(1'b0)) u_req_sync
  (
    .clk(bit_clk),
    .rstn(link_rstn),
    .din(req_tgl),
    .dout(req_sync)
  );

  assign link_apply = (req_sync != ack_tgl);

  // Answer each request once
  always_ff @(posedge bit_clk)
  begin
    if (!link_rstn)
      ack_tgl <= 1'b0;
    else if (link_apply)
      ack_tgl <= ~ack_tgl;
  end

  // [RULE15] apply set and clear on the link
  // [RULE6] GP clears
  // [RULE7] modem clears
  // [RULE8] audio receive clear
  always_ff @(posedge bit_clk)
  begin
    if (!link_rstn)
      link_state <= aclsc_pkg::SLOT_RESET;
    else if (link_apply)
      link_state <= (link_state | set_mask) & ~clr_mask;
  end

  // Slot enables to the frame engine
  // [RULE2] LFE and other slot outputs
  assign pcm_tx_slot_en = link_state[aclsc_pkg::PCM_TX_BIT];
  assign surround_tx_slot_en = link_state[aclsc_pkg::SURROUND_TX_BIT];
  assign center_tx_slot_en = link_state[aclsc_pkg::CENTER_TX_BIT];
  assign lfe_tx_slot_en = link_state[aclsc_pkg::LFE_TX_BIT];
  assign audio_rx_slot_en = link_state[aclsc_pkg::AUDIO_RX_BIT];
  assign modem_tx_slot_en = link_state[aclsc_pkg::MODEM_TX_BIT];
  assign modem_rx_slot_en = link_state[aclsc_pkg::MODEM_RX_BIT];
  assign gp_output_slot_en = link_state[aclsc_pkg::GP_OUTPUT_BIT];
  assign gp_input_slot_en = link_state[aclsc_pkg::GP_INPUT_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Accepted write to either register
  sequence seq_write_accept;
    wr_go;
  endsequence

  // Acknowledge closes the pending window
  sequence seq_ack_close;
    $fell(write_pending);
  endsequence

  // Pending rises and holds across the crossing
  AST_PEND_AFTER_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE11]
    seq_write_accept |=> write_pending [*3])
    else $error("pending not held after write");

  // Set bits are on once the write completes
  AST_SET_APPLIED: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE1]
    seq_ack_close |-> ((slot_state & $past(set_mask)) == $past(set_mask)))
    else $error("set bits not applied");

  // Cleared bits are off once the write completes
  AST_CLEAR_APPLIED: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE9]
    seq_ack_close |-> ((slot_state & $past(clr_mask)) == aclsc_pkg::SLOT_RESET))
    else $error("clear bits not applied");

  // Bits written as zero keep their value
  AST_ZERO_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE8]
    seq_ack_close |-> ((slot_state & ~$past(set_mask) & ~$past(clr_mask)) ==
      ($past(slot_state) & ~$past(set_mask) & ~$past(clr_mask))))
    else $error("unwritten slot bit changed");

  // Reserved slot bit never becomes set
  AST_RESERVED_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE10]
    (slot_state & ~aclsc_pkg::SLOT_MASK) == aclsc_pkg::SLOT_RESET)
    else $error("reserved bit set");

  // Read of the enable register returns the pending flag
  AST_READ_PENDING: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE14]
    (setup_phase && !pwrite && hit_enable) |=>
      (prdata[aclsc_pkg::PENDING_BIT] == $past(write_pending)))
    else $error("pending flag misread");

  // State stays put while a write is in flight
  AST_STATE_HELD: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE12]
    (write_pending && $past(write_pending)) |-> $stable(slot_state) && $stable(set_mask))
    else $error("state moved while pending");

  // Reset leaves every slot disabled and nothing pending
  AST_RESET_CLEAR: assert property (@(posedge ref_clk) // [RULE16]
    !rstn |=> (slot_state == aclsc_pkg::SLOT_RESET) && !write_pending)
    else $error("reset did not clear state");

  // Link state only moves together with an acknowledge
  AST_LINK_WITH_ACK: assert property (@(posedge bit_clk) disable iff (!link_rstn) // [RULE15]
    !$stable(link_state) |-> !$stable(ack_tgl))
    else $error("link state moved without ack");

  // Link copy agrees with the host copy once a write completes
  AST_LINK_MATCH: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE15]
    seq_ack_close |-> (link_state == slot_state))
    else $error("link state differs from host copy");

  // Ready answers each setup for exactly one cycle
  AST_READY_PULSE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE14]
    setup_phase |=> pready ##1 !pready)
    else $error("ready not a single pulse");

endmodule

`default_nettype wire

// >>> aclsc_pkg.sv
// Constants and types shared by the slot enable control block
`default_nettype none

package aclsc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] SLOT_ENABLE_OFF = 16'hf748;
  localparam logic [15:0] SLOT_DISABLE_OFF = 16'hf74c;

  // ----------------------------------------------------------------
  // Slot field positions, shared by both registers
  // ----------------------------------------------------------------
  localparam int SLOT_W = 10;
  localparam int PCM_TX_BIT = 0;
  localparam int SURROUND_TX_BIT = 1;
  localparam int CENTER_TX_BIT = 2;
  localparam int LFE_TX_BIT = 3;
  localparam int AUDIO_RX_BIT = 4;
  localparam int MODEM_TX_BIT = 6;
  localparam int MODEM_RX_BIT = 7;
  localparam int GP_OUTPUT_BIT = 8;
  localparam int GP_INPUT_BIT = 9;
  localparam int PENDING_BIT = 16;

  // Implemented slot bits; bit 5 and bits above 9 are reserved
  localparam logic [9:0] SLOT_MASK = 10'h3df;
  localparam logic [9:0] SLOT_RESET = 10'h000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Write handshake state
  // ----------------------------------------------------------------
  typedef enum logic
  {
    ACLSC_WR_IDLE = 1'b0,
    ACLSC_WR_BUSY = 1'b1
  } aclsc_wr_e;

endpackage

`default_nettype wire

// >>> aclsc_sync3.sv
// Three-stage synchroniser with agreement filter for one level
`timescale 1ns/1ps
`default_nettype none

module aclsc_sync3
#(
  parameter logic RESET_VALUE = 1'b0
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ----------------------------------------------------------------
  // Capture chain
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
    end
    else
    begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Output follows once the last two stages agree
  always_ff @(posedge clk)
  begin
    if (!rstn)
      dout <= RESET_VALUE;
    else if (stage2 == stage3)
      dout <= stage3;
  end

endmodule

`default_nettype wire

// >>> aclsc_codec_model.sv
// Behavioural codec end of the link: supplies the bit clock
`timescale 1ns/1ps
`default_nettype none

module aclsc_codec_model
(
  input wire logic run,
  output logic bit_clk
);
  // Bit clock, 6 ns period, parked low while stopped
  initial
  begin
    bit_clk = 1'b0;
    #1.7;
    forever
    begin
      if (run)
        bit_clk = ~bit_clk;
      else
        bit_clk = 1'b0;
      #3;
    end
  end
endmodule

`default_nettype wire

// >>> test_aclink_slot_enable_control.sv
// Self-checking bench for the slot enable control register bank
`timescale 1ns/1ps
`default_nettype none

module test_aclink_slot_enable_control;
  localparam logic [15:0] EN = aclsc_pkg::SLOT_ENABLE_OFF;
  localparam logic [15:0] DIS = aclsc_pkg::SLOT_DISABLE_OFF;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, run, err, bit_clk;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] link;
  assign link[5] = 1'b0; // Reserved slot position has no output
  int n_errors = 0;
  int checks = 0;
  int exp_st = 0;

  // ----------------------------------------------------------------
  // Design, codec model and clock
  // ----------------------------------------------------------------
  aclsc_slot_ctrl uut
  (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_clk(bit_clk),
    .pcm_tx_slot_en(link[0]), .surround_tx_slot_en(link[1]),
    .center_tx_slot_en(link[2]), .lfe_tx_slot_en(link[3]),
    .audio_rx_slot_en(link[4]), .modem_tx_slot_en(link[6]),
    .modem_rx_slot_en(link[7]), .gp_output_slot_en(link[8]),
    .gp_input_slot_en(link[9])
  );

  aclsc_codec_model codec
  (
    .run(run),
    .bit_clk(bit_clk)
  );

  // Host clock, 20 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever
      #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Compare, report and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_rd(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_link(input logic [9:0] exp);
    checks++;
    if ((link & 10'h3df) !== exp)
    begin
      n_errors++;
      $display("unexpected slot outputs: expected %h, seen %h", exp, link & 10'h3df);
    end
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One APB transfer; result left in rd and err
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll the enable register until no write is pending
  task automatic wait_idle;
    do
      apb(1'b0, EN, 32'h0);
    while (rd[aclsc_pkg::PENDING_BIT] !== 1'b0);
  endtask

  // Write, see pending, update model, wait and compare
  task automatic wr_slot(input logic dis, input logic [31:0] d);
    apb(1'b1, dis ? DIS : EN, d);
    chk_rd("write error", 32'h0, {31'h0, err});
    apb(1'b0, EN, 32'h0);
    chk_rd("pending read", 32'h10000 | exp_st, rd);
    if (dis)
      exp_st = exp_st & ~int'(d) & 'h3df;
    else
      exp_st = (exp_st | int'(d)) & 'h3df;
    wait_idle();
    chk_rd("slot state", exp_st, rd);
    chk_link(exp_st[9:0]);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    run = 1'b1;
    void'($urandom(32'he694e605));
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, EN, 32'h0);
    chk_rd("reset state", 32'h0, rd);
    chk_link(10'h0);
    end_test("reset");
    // set one slot at a time
    for (int b = 0; b < 10; b++)
      if (b != 5)
        wr_slot(1'b0, 32'h1 << b);
    wr_slot(1'b1, 32'hfffffc20);
    // clear one slot at a time
    for (int b = 0; b < 10; b++)
      if (b != 5)
        wr_slot(1'b1, (32'h1 << b) | 32'hfffffc20);
    end_test("set and clear");
    repeat (12)
      wr_slot(1'($urandom_range(0, 1)), $urandom);
    end_test("random");
    // second write while pending is dropped
    wr_slot(1'b1, 32'h3ff);
    apb(1'b1, EN, 32'h1);
    apb(1'b1, EN, 32'h2);
    exp_st = 1;
    wait_idle();
    chk_rd("dropped write", exp_st, rd);
    apb(1'b1, 16'hf740, 32'hffffffff);
    chk_rd("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, DIS, 32'h0);
    chk_rd("disable read", 32'h0, rd);
    apb(1'b0, EN, 32'h0);
    chk_rd("after unmapped", exp_st, rd);
    end_test("refusals");
    run <= 1'b0;
    apb(1'b1, EN, 32'h3c0);
    repeat (100) @(posedge ref_clk);
    apb(1'b0, EN, 32'h0);
    chk_rd("stalled pending", 32'h10000 | exp_st, rd);
    run <= 1'b1;
    exp_st = exp_st | 'h3c0;
    wait_idle();
    chk_rd("after restart", exp_st, rd);
    chk_link(exp_st[9:0]);
    end_test("stopped clock");
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial
  begin
    #1000000;
    n_errors++;
    $display("unexpected watchdog: expected finish, seen timeout");
    tally_and_finish();
  end
endmodule

`default_nettype wire
